// ===== logic/sstl_cfg.svh
// Offsets, field positions, reset values and timing counts of the sensor SPI port
`ifndef SSTL_CFG_SVH
`define SSTL_CFG_SVH
// ==========================================
// Primary register byte addresses (even = high byte)
`define SSTL_A_ZERO 6'h00
`define SSTL_A_XADDR 6'h02
`define SSTL_A_EWDH 6'h04
`define SSTL_A_EWDL 6'h06
`define SSTL_A_XCTRL 6'h08
`define SSTL_A_XRDAT 6'h0a
`define SSTL_A_CTRL 6'h1e
`define SSTL_A_STAT 6'h20
`define SSTL_A_WARN 6'h22
`define SSTL_A_TRN_HI 6'h2c
`define SSTL_A_TRN_LO 6'h2e
// ==========================================
// Command codes and fields
`define SSTL_SPC_TRST 4'h1
`define SSTL_SPC_LOAD 4'h3
`define SSTL_SPC_TPM 4'h6
`define SSTL_INIT_KEY 8'h46
`define SSTL_XC_WGO 7
`define SSTL_XC_RGO 6
`define SSTL_W_IER 0
`define SSTL_W_CRC 1
`define SSTL_RST_WORD 16'h0000
// ==========================================
// Frame lengths and CRC
`define SSTL_LEN16 5'h10
`define SSTL_LEN17 5'h11
`define SSTL_LEN20 5'h14
`define SSTL_CRC_SEED 4'hf
`define SSTL_CRC_POLY 4'h3
// ==========================================
// Turns arithmetic and timing
`define SSTL_HALF_REV 21'sh000800
`define SSTL_FULL_REV 21'sh001000
`define SSTL_CLK_MHZ 100
`define SSTL_TPM_LOW_NS 64000
`define SSTL_TPM_LOW_CYC ((`SSTL_TPM_LOW_NS * `SSTL_CLK_MHZ + 999) / 1000)
`endif

// ===== logic/sstl_pkg.sv
// Types and the CRC function of the sensor SPI port
package sstl_pkg;
  // ==========================================
  // State of the system clock domain
  typedef struct packed {
    logic [1:0] cs_s;
    logic cs_p;
    logic [1:0] sck_s;
    logic [1:0] mosi_s;
    logic [1:0] tog_s;
    logic seen;
    logic [15:0] low_cnt;
    logic armed;
    logic tmode;
    logic [19:0] txf;
    logic [15:0] xaddr;
    logic [15:0] ewdh;
    logic [15:0] ewdl;
    logic [15:0] xrdat;
    logic [7:0] init;
    logic [3:0] spec;
    logic xdone;
    logic xwr;
    logic xrd;
    logic ier;
    logic crcw;
    logic [20:0] turns;
  } sstl_sys_t;
  // Working receive state, cleared while chip select is high
  typedef struct packed {
    logic [4:0] rcnt;
    logic [19:0] rsh;
  } sstl_rx_t;
  // Snapshot handed to the system domain
  typedef struct packed {
    logic [4:0] cnt;
    logic [19:0] dat;
    logic tog;
  } sstl_snap_t;
  // ==========================================
  // Frame CRC, MSB first, preset all ones
  function automatic logic [3:0] sstl_crc4(input logic [15:0] d);
    logic [3:0] c;
    logic inv;
    c = 4'hf;
    for (int i = 15; i >= 0; i--) begin
      inv = d[i] ^ c[3];
      c = {c[2:0], 1'b0} ^ ({4{inv}} & 4'h3);
    end
    return c;
  endfunction
endpackage

// ===== logic/sstl_top.sv
// SPI slave port of the angle sensor with turns load and transport mode
`include "sstl_cfg.svh"
// Function
// - Counter-reset special command clears the turns counter.
// - Direct SPI writes to the turns registers are ignored.
// - Special 0x3 with initiate 0x46 starts a turns load.
// - Policy 00/01 copies the loaded value and keeps accumulating.
// - Policy 10/11 snaps to nearest value matching sensed angle.
// - Special 0x6 arms transport mode, entered after inputs low past 64 us.
// - Any SPI input high leaves transport mode at once.
// - Locking blocks extended writes from SPI and supply line.
// - Supply-line disable ignores its commands; SPI keeps working.
// - Extended reads and writes run through primary registers.
// - SPI mode 3, clock idles high, capture on second edge.
// - Frames of 16, 20, or 17 bits when enabled are accepted.
// - Extra clock pulses raise the interface warning flag.
// - Frame is zero, write bit, 6 address, 8 data, optional CRC.
// - Host data bits are sampled on rising serial clock.
// - Read data returns in the next frame; reads may pipeline.
// - All-zero frame reads 0x00, changes nothing, returns zero.
// - Even address reads full word; odd reads one byte, upper zero.
// - CRC x^4+x+1, preset ones, 16 payload bits MSB first.
// - With check enabled, bad CRC frames are dropped and flagged.
module sstl_top
  import sstl_pkg::*;
#(
  parameter int TPM_CYC = `SSTL_TPM_LOW_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_spi_sclk,
  input wire logic i_chip_select_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  input wire logic i_seventeen_bit_frame_enable,
  input wire logic i_incoming_crc_check_enable,
  input wire logic i_supply_line_if_disable,
  input wire logic i_eeprom_lock,
  input wire logic i_transport_disable,
  input wire logic [1:0] i_startup_policy,
  input wire logic i_sys_stable,
  input wire logic [11:0] i_angle,
  input wire logic i_angle_step_valid,
  input wire logic [12:0] i_angle_step,
  input wire logic [15:0] i_xmem_rdata,
  input wire logic i_xmem_done,
  input wire logic i_supply_cmd_valid,
  input wire logic i_supply_cmd_write,
  output logic o_supply_cmd_accept,
  output logic o_xmem_wr,
  output logic o_xmem_rd,
  output logic [15:0] o_xmem_addr,
  output logic [31:0] o_xmem_wdata,
  output logic [20:0] o_turns,
  output logic o_transport_mode,
  output logic o_lfo_enable,
  output logic o_wake_enable,
  output logic o_warn_ier,
  output logic o_warn_crc
);
  // ==========================================
  // Link domain: receive on rising edge, held clear while deselected
  sstl_rx_t rx_q, rx_d;
  sstl_snap_t sn_q, sn_d;
  sstl_sys_t s_q, s_d;
  logic [4:0] fcnt_q;
  logic [4:0] idx;

  always_comb begin
    rx_d = rx_q;
    rx_d.rsh = {rx_q.rsh[18:0], i_spi_mosi};
    if (rx_q.rcnt != 5'h1f) begin
      rx_d.rcnt = rx_q.rcnt + 5'h01;
    end
    sn_d.cnt = rx_d.rcnt;
    sn_d.dat = rx_d.rsh;
    // Toggle once per frame so empty selects are never taken as frames
    sn_d.tog = (rx_q.rcnt == 5'h00) ? ~sn_q.tog : sn_q.tog;
  end

  // Chip select high clears the counter, so each frame starts at bit 0
  always_ff @(posedge i_spi_sclk or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end

  // Snapshot survives chip select; a clock edge while deselected is no frame
  always_ff @(posedge i_spi_sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sn_q <= '0;
    end else if (!i_chip_select_n) begin
      sn_q <= sn_d;
    end
  end

  // Output bits change on falling edges, host captures on rising (mode 3)
  always_ff @(negedge i_spi_sclk or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      fcnt_q <= 5'h00;
    end else if (fcnt_q != 5'h1f) begin
      fcnt_q <= fcnt_q + 5'h01;
    end
  end

  // Response word is static during a frame, so reading it here is safe
  always_comb begin
    idx = (fcnt_q == 5'h00) ? 5'h00 : fcnt_q - 5'h01;
    o_spi_miso = (idx < `SSTL_LEN20) ? s_q.txf[5'd19 - idx] : 1'b0;
  end

  // ==========================================
  // System domain: frame decode
  logic fe, l16, l17, l20, legal, crc_bad, acc, wr;
  logic [15:0] pay, rdw, rsp;
  logic [5:0] addr;
  logic [7:0] wd;
  logic cmd, load, trst, anyhi;
  logic signed [20:0] lval, cand, diff;

  // Frame end: synced chip select rose and a clocked frame occurred
  always_comb begin
    fe = s_q.cs_s[1] & ~s_q.cs_p & (s_q.tog_s[1] != s_q.seen);
    l16 = sn_q.cnt == `SSTL_LEN16;
    l17 = (sn_q.cnt == `SSTL_LEN17) & i_seventeen_bit_frame_enable;
    l20 = sn_q.cnt == `SSTL_LEN20;
    legal = l16 | l17 | l20;
    pay = l20 ? sn_q.dat[19:4] : (l17 ? sn_q.dat[16:1] : sn_q.dat[15:0]);
    crc_bad = l20 & i_incoming_crc_check_enable & (sstl_crc4(pay) != sn_q.dat[3:0]);
    acc = fe & legal & ~crc_bad & ~pay[15];
    wr = pay[14];
    addr = pay[13:8];
    wd = pay[7:0];
  end

  // Register read mux on the even word address
  always_comb begin
    unique case ({addr[5:1], 1'b0})
      `SSTL_A_XADDR: rdw = s_q.xaddr;
      `SSTL_A_EWDH: rdw = s_q.ewdh;
      `SSTL_A_EWDL: rdw = s_q.ewdl;
      `SSTL_A_XCTRL: rdw = {15'h0000, s_q.xdone};
      `SSTL_A_XRDAT: rdw = s_q.xrdat;
      `SSTL_A_CTRL: rdw = {s_q.init, 4'h0, s_q.spec};
      `SSTL_A_STAT: rdw = {13'h0000, s_q.tmode, s_q.armed, i_sys_stable};
      `SSTL_A_WARN: rdw = {14'h0000, s_q.crcw, s_q.ier};
      `SSTL_A_TRN_HI: rdw = {11'h000, s_q.turns[20:16]};
      `SSTL_A_TRN_LO: rdw = s_q.turns[15:0];
      default: rdw = `SSTL_RST_WORD; // Register 0x00 and holes read zero
    endcase
    rsp = addr[0] ? {8'h00, rdw[7:0]} : rdw;
    if (!acc || wr) begin
      rsp = `SSTL_RST_WORD;
    end
  end

  // Turns command decode and snap arithmetic
  always_comb begin
    cmd = acc & wr & (addr == `SSTL_A_CTRL) & (wd == `SSTL_INIT_KEY);
    load = cmd & (s_q.spec == `SSTL_SPC_LOAD);
    trst = cmd & (s_q.spec == `SSTL_SPC_TRST);
    lval = {s_q.ewdh[4:0], s_q.ewdl};
    cand = {lval[20:12], i_angle};
    diff = cand - lval;
    // Nearest match to the angle: fold by one revolution if off by more than half
    if (diff > `SSTL_HALF_REV) begin
      cand = cand - `SSTL_FULL_REV;
    end else if (diff < -`SSTL_HALF_REV) begin
      cand = cand + `SSTL_FULL_REV;
    end
    anyhi = s_q.cs_s[1] | s_q.sck_s[1] | s_q.mosi_s[1];
  end

  // ==========================================
  // System domain next state
  always_comb begin
    s_d = s_q;
    s_d.cs_s = {s_q.cs_s[0], i_chip_select_n};
    s_d.cs_p = s_q.cs_s[1];
    s_d.sck_s = {s_q.sck_s[0], i_spi_sclk};
    s_d.mosi_s = {s_q.mosi_s[0], i_spi_mosi};
    s_d.tog_s = {s_q.tog_s[0], sn_q.tog};
    s_d.xwr = 1'b0;
    s_d.xrd = 1'b0;
    if (fe) begin
      s_d.seen = s_q.tog_s[1];
      s_d.txf = {rsp, sstl_crc4(rsp)};
    end
    // Byte writes; turns registers are absent here on purpose
    if (acc && wr) begin
      unique case (addr)
        `SSTL_A_XADDR: s_d.xaddr[15:8] = wd;
        6'h03: s_d.xaddr[7:0] = wd;
        `SSTL_A_EWDH: s_d.ewdh[15:8] = wd;
        6'h05: s_d.ewdh[7:0] = wd;
        `SSTL_A_EWDL: s_d.ewdl[15:8] = wd;
        6'h07: s_d.ewdl[7:0] = wd;
        `SSTL_A_XCTRL: begin
          s_d.xwr = wd[`SSTL_XC_WGO] & ~i_eeprom_lock;
          s_d.xrd = wd[`SSTL_XC_RGO];
          if (wd[`SSTL_XC_RGO]) begin
            s_d.xdone = 1'b0;
          end
        end
        `SSTL_A_CTRL: s_d.init = wd;
        6'h1f: s_d.spec = wd[3:0];
        6'h23: begin
          s_d.ier = s_q.ier & ~wd[`SSTL_W_IER];
          s_d.crcw = s_q.crcw & ~wd[`SSTL_W_CRC];
        end
        default: ;
      endcase
    end
    // Flag sets come after clears so a same-cycle event is kept
    if (fe && !legal && (sn_q.cnt > `SSTL_LEN16)) begin
      s_d.ier = 1'b1;
    end
    if (fe && crc_bad) begin
      s_d.crcw = 1'b1;
    end
    if (i_xmem_done) begin
      s_d.xdone = 1'b1;
      s_d.xrdat = i_xmem_rdata;
    end
    // Commands win over accumulation in the same cycle
    if (trst) begin
      s_d.turns = 21'h000000;
    end else if (load && !i_startup_policy[1]) begin
      s_d.turns = lval;
    end else if (load) begin
      s_d.turns = cand;
    end else if (i_angle_step_valid) begin
      s_d.turns = s_q.turns + {{8{i_angle_step[12]}}, i_angle_step};
    end
    if (cmd && (s_q.spec == `SSTL_SPC_TPM)) begin
      s_d.armed = 1'b1;
    end
    // Low-input timer; saturates so it never wraps back under the limit
    if (anyhi) begin
      s_d.low_cnt = 16'h0000;
      s_d.tmode = 1'b0;
    end else if (s_q.low_cnt != 16'hffff) begin
      s_d.low_cnt = s_q.low_cnt + 16'h0001;
    end
    if (!anyhi && s_q.armed && !i_transport_disable && (s_q.low_cnt >= 16'(TPM_CYC))) begin
      s_d.tmode = 1'b1;
      s_d.armed = 1'b0;
    end
  end

  // Register the whole system state
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
      s_q.cs_s <= 2'h3;
      s_q.cs_p <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // Outputs
  assign o_supply_cmd_accept = i_supply_cmd_valid & ~i_supply_line_if_disable
    & ~(i_supply_cmd_write & i_eeprom_lock);
  assign o_xmem_wr = s_q.xwr;
  assign o_xmem_rd = s_q.xrd;
  assign o_xmem_addr = s_q.xaddr;
  assign o_xmem_wdata = {s_q.ewdh, s_q.ewdl};
  assign o_turns = s_q.turns;
  assign o_transport_mode = s_q.tmode;
  assign o_lfo_enable = ~s_q.tmode;
  assign o_wake_enable = ~s_q.tmode;
  assign o_warn_ier = s_q.ier;
  assign o_warn_crc = s_q.crcw;

  // ==========================================
  // Checks
  property p_trst;
    @(posedge i_sys_clk) disable iff (i_sys_rst) trst |=> (o_turns == 21'h000000);
  endproperty
  a_trst: assert property (p_trst) else $error("turns not cleared");

  property p_nowr;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (acc && wr && (addr[5:1] == 5'h17) && !i_angle_step_valid) |=> $stable(o_turns);
  endproperty
  a_nowr: assert property (p_nowr) else $error("turns written directly");

  property p_load;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (load && !i_startup_policy[1]) |=> (o_turns == $past(o_xmem_wdata[20:0]));
  endproperty
  a_load: assert property (p_load) else $error("loaded value not copied");

  property p_snap;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (load && i_startup_policy[1]) |=> (o_turns[11:0] == $past(i_angle));
  endproperty
  a_snap: assert property (p_snap) else $error("snap ignores angle");

  property p_tpm;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      $rose(o_transport_mode) |-> ($past(s_q.armed) && ($past(s_q.low_cnt) >= 16'(TPM_CYC)));
  endproperty
  a_tpm: assert property (p_tpm) else $error("transport entered early");

  property p_wake;
    @(posedge i_sys_clk) disable iff (i_sys_rst) (anyhi && o_transport_mode) |=> !o_transport_mode;
  endproperty
  a_wake: assert property (p_wake) else $error("transport not left");

  property p_ier;
    @(posedge i_sys_clk) disable iff (i_sys_rst) (fe && (sn_q.cnt > `SSTL_LEN20)) |=> o_warn_ier;
  endproperty
  a_ier: assert property (p_ier) else $error("long frame not flagged");

  property p_crc;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (fe && crc_bad) |=> (o_warn_crc && $stable(o_xmem_wdata) && !o_xmem_wr);
  endproperty
  a_crc: assert property (p_crc) else $error("bad crc frame used");

  property p_odd;
    @(posedge i_sys_clk) disable iff (i_sys_rst) (acc && !wr && addr[0]) |=> (s_q.txf[19:12] == 8'h00);
  endproperty
  a_odd: assert property (p_odd) else $error("odd read upper byte set");

  property p_zero;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (acc && l16 && (pay == 16'h0000)) |=> (s_q.txf[19:4] == 16'h0000) && $stable(o_turns);
  endproperty
  a_zero: assert property (p_zero) else $error("zero frame not neutral");

  property p_lock;
    @(posedge i_sys_clk) disable iff (i_sys_rst) o_xmem_wr |-> !$past(i_eeprom_lock);
  endproperty
  a_lock: assert property (p_lock) else $error("write while locked");
endmodule

// ===== test/sstl_host.sv
// Host-side SPI master model in mode 3 for the sensor port bench
module sstl_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Idle levels: clock high, deselected
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // One frame of n bits, MSB first; a 17-bit frame gives the late-sampling edge
  task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = '0;
    #1.7 o_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #3 o_sclk = 1'b0;
      o_mosi = tx[23 - i];
      #3 o_sclk = 1'b1;
      rx[23 - i] = i_miso;
    end
    #3 o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    // Gap well above five system cycles
    #100;
  endtask
  // All inputs low so the device can go to sleep
  task automatic park();
    o_cs_n = 1'b0;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  endtask
  // Chip select alone wakes; clock returns to idle later
  task automatic wake();
    o_cs_n = 1'b1;
    #40;
    o_sclk = 1'b1;
    // Keep deselected long enough before any next frame
    #60;
  endtask
endmodule

// ===== test/tb_top.sv
// Self-checking bench of the sensor SPI port
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, mosi, miso, s17, crce, sdis, lock, stab, sv, sw, xdone, acc, xwr, xrd;
  logic tmode, lfo, wake, wier, wcrc, tpd, stv;
  logic [12:0] stp;
  logic [1:0] pol;
  logic [11:0] ang;
  logic [15:0] xrdat, xaddr;
  logic [31:0] wdat;
  logic [20:0] turns;
  int bad_count = 0;
  int checks_done = 0;
  int nwr = 0;
  int nrd = 0;
  always #5 clk = ~clk;
  // ==========================================
  // Partner and design
  sstl_host u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));
  sstl_top #(.TPM_CYC(20)) u_dut (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_spi_sclk(sclk), .i_chip_select_n(cs_n),
    .i_spi_mosi(mosi), .o_spi_miso(miso), .i_seventeen_bit_frame_enable(s17),
    .i_incoming_crc_check_enable(crce), .i_supply_line_if_disable(sdis),
    .i_eeprom_lock(lock), .i_transport_disable(tpd), .i_startup_policy(pol),
    .i_sys_stable(stab), .i_angle(ang), .i_angle_step_valid(stv), .i_angle_step(stp),
    .i_xmem_rdata(xrdat), .i_xmem_done(xdone), .i_supply_cmd_valid(sv),
    .i_supply_cmd_write(sw), .o_supply_cmd_accept(acc), .o_xmem_wr(xwr), .o_xmem_rd(xrd),
    .o_xmem_addr(xaddr), .o_xmem_wdata(wdat), .o_turns(turns), .o_transport_mode(tmode),
    .o_lfo_enable(lfo), .o_wake_enable(wake), .o_warn_ier(wier), .o_warn_crc(wcrc)
  );
  // Count extended-access pulses
  always @(posedge clk) begin
    if (xwr === 1'b1) nwr++;
    if (xrd === 1'b1) nrd++;
  end
  // ==========================================
  // Helpers
  function automatic logic [3:0] crc(input logic [15:0] d);
    logic [3:0] c;
    logic inv;
    c = 4'hf;
    for (int i = 15; i >= 0; i--) begin
      inv = d[i] ^ c[3];
      c = {c[2:0], 1'b0} ^ ({4{inv}} & 4'h3);
    end
    return c;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [23:0] rx;
    u_host.xfer(16, {2'b01, a, d, 8'h00}, rx);
  endtask
  // Read frame, then a zero frame carrying the answer; earlier output ignored
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    logic [23:0] rx;
    u_host.xfer(16, {2'b00, a, 16'h0000}, rx);
    u_host.xfer(20, {16'h0000, crc(16'h0000), 4'h0}, rx);
    chk("read", {12'h000, e, crc(e)}, {12'h000, rx[23:4]});
  endtask
  task automatic cmd(input logic [7:0] code);
    wr(6'h1f, code);
    wr(6'h1e, 8'h46);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_ewd();
    logic [23:0] rx;
    wr(6'h04, 8'h00);
    wr(6'h05, 8'h01);
    wr(6'h06, 8'hd0);
    wr(6'h07, 8'h0f);
    chk("wdata", 32'h0001d00f, wdat);
    rd(6'h06, 16'hd00f);
    rd(6'h07, 16'h000f);
    u_host.xfer(16, {2'b00, 6'h04, 16'h0000}, rx);
    u_host.xfer(16, {2'b00, 6'h07, 16'h0000}, rx);
    chk("pipe1", 32'h0001, {16'h0000, rx[23:8]});
    u_host.xfer(16, 24'h000000, rx);
    chk("pipe2", 32'h000f, {16'h0000, rx[23:8]});
    u_host.xfer(16, 24'h000000, rx);
    chk("zero", 32'h0000, {16'h0000, rx[23:8]});
    $display("test ewd done");
  endtask
  task automatic t_load();
    @(posedge clk) stab <= 1'b1;
    rd(6'h20, 16'h0001);
    cmd(8'h03);
    chk("copy", 32'h01d00f, {11'h000, turns});
    wr(6'h2e, 8'h55);
    chk("direct", 32'h01d00f, {11'h000, turns});
    rd(6'h2e, 16'hd00f);
    // Minus five counts accumulate on top of the loaded value
    @(posedge clk) stv <= 1'b1;
    stp <= 13'h1ffb;
    @(posedge clk) stv <= 1'b0;
    #1 chk("accum", 32'h01d00a, {11'h000, turns});
    cmd(8'h01);
    chk("treset", 32'h0, {11'h000, turns});
    @(posedge clk) pol <= 2'b10;
    ang <= 12'h010;
    cmd(8'h03);
    chk("snap", 32'h01d010, {11'h000, turns});
    @(posedge clk) pol <= 2'b11;
    ang <= 12'hff0;
    cmd(8'h03);
    chk("snapfold", 32'h01cff0, {11'h000, turns});
    $display("test load done");
  endtask
  task automatic t_len();
    logic [23:0] rx;
    u_host.xfer(20, {16'h4501, crc(16'h4501), 4'h0}, rx);
    chk("ier20", 32'h0, {31'h0, wier});
    u_host.xfer(17, 24'h000000, rx);
    chk("ier17off", 32'h1, {31'h0, wier});
    wr(6'h23, 8'h01);
    chk("ierclr", 32'h0, {31'h0, wier});
    @(posedge clk) s17 <= 1'b1;
    u_host.xfer(17, 24'h000000, rx);
    chk("ier17on", 32'h0, {31'h0, wier});
    u_host.xfer(24, 24'h000000, rx);
    chk("ier24", 32'h1, {31'h0, wier});
    wr(6'h23, 8'h01);
    @(posedge clk) crce <= 1'b1;
    u_host.xfer(20, {16'h47aa, ~crc(16'h47aa), 4'h0}, rx);
    chk("crcw", 32'h1, {31'h0, wcrc});
    chk("crcdrop", 32'h0001d00f, wdat);
    $display("test len done");
  endtask
  task automatic t_xmem();
    wr(6'h08, 8'h80);
    @(posedge clk) lock <= 1'b1;
    wr(6'h08, 8'h80);
    chk("wrgo", 32'h1, nwr);
    @(posedge clk) lock <= 1'b0;
    wr(6'h02, 8'h12);
    wr(6'h03, 8'h34);
    chk("xaddr", 32'h1234, {16'h0000, xaddr});
    wr(6'h08, 8'h40);
    chk("rdgo", 32'h1, nrd);
    @(posedge clk) xrdat <= 16'h5a3c;
    xdone <= 1'b1;
    @(posedge clk) xdone <= 1'b0;
    rd(6'h0a, 16'h5a3c);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) {lock, sdis} <= k[1:0];
      @(posedge clk);
      #1 chk("accept", {31'h0, k == 0}, {31'h0, acc});
    end
    rd(6'h06, 16'hd00f);
    // Lock refuses only supply-line writes, reads still pass
    @(posedge clk) {lock, sdis, sw} <= 3'b100;
    @(posedge clk);
    #1 chk("readok", 32'h1, {31'h0, acc});
    @(posedge clk) lock <= 1'b0;
    $display("test xmem done");
  endtask
  task automatic t_tpm();
    int i;
    cmd(8'h06);
    u_host.park();
    for (i = 0; i < 200 && tmode !== 1'b1; i++) @(posedge clk);
    #1 chk("tmode", 32'h1, {31'h0, tmode});
    if (tmode !== 1'b1) summarize();
    chk("tpmwait", 32'h1, {31'h0, i >= 20});
    chk("lfo", 32'h0, {30'h0, lfo, wake});
    u_host.wake();
    chk("woken", 32'h2, {30'h0, lfo, tmode});
    // Armed again but disabled: long low inputs must not enter
    @(posedge clk) tpd <= 1'b1;
    cmd(8'h06);
    u_host.park();
    repeat (40) @(posedge clk);
    #1 chk("tpmoff", 32'h0, {31'h0, tmode});
    u_host.wake();
    $display("test tpm done");
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {s17, crce, sdis, lock, stab, xdone, tpd, stv} = '0;
    stp = 13'h0000;
    {sv, sw} = 2'b11;
    pol = 2'b00;
    ang = 12'h000;
    xrdat = 16'h0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("rst", 32'h1, {31'h0, lfo});
    t_ewd();
    t_load();
    t_len();
    t_xmem();
    t_tpm();
    summarize();
  end
endmodule
